/* File: rtl/cip_defines.svh */
// Offsets, field positions, reset values and codes of the charger serial port
`ifndef CIP_DEFINES_SVH
`define CIP_DEFINES_SVH

// =============================================================
// Bus addressing
`define CIP_TARGET_ADDR    7'h6B
`define CIP_LAST_REG       8'h0B
`define CIP_FAULT_REG      8'h09
`define CIP_SKIP_FROM      8'h08
`define CIP_AFTER_FAULT    8'h0A
`define CIP_PTR_MAX        8'hFF
`define CIP_BEYOND_VALUE   8'hFF
`define CIP_EMPTY_VALUE    8'h00
`define CIP_BYTE_BITS      4'h8
`define CIP_LAST_BIT       4'h7

// =============================================================
// Register offsets
`define CIP_OFS_INPUT_CTRL 8'h00
`define CIP_OFS_CHARGE_CTRL 8'h01

// =============================================================
// Reset values and watchdog restore masks
`define CIP_RST_INPUT_CTRL 8'h17
`define CIP_RST_CHARGE_CTRL 8'h1A
`define CIP_WD_MASK_INPUT  8'h80
`define CIP_WD_MASK_CHARGE 8'h70

// =============================================================
// Field positions
`define CIP_HIZ_BIT        7
`define CIP_PIN_SEL_HI     6
`define CIP_PIN_SEL_LO     5
`define CIP_ILIM_HI        4
`define CIP_PFM_BIT        7
`define CIP_KICK_BIT       6
`define CIP_BOOST_BIT      5
`define CIP_CHG_BIT        4
`define CIP_FLOOR_HI       3
`define CIP_FLOOR_LO       1
`define CIP_BATSEL_BIT     0
`define CIP_PIN_FLOAT_CODE 2'b11

`endif

/* File: rtl/cip_pair_buffer.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps

module cip_pair_buffer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    // Filling side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Draining side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    import cip_pkg::*;

    logic [WIDTH-1:0] mem_ff [2];
    logic [WIDTH-1:0] nxt_mem [2];
    logic             wr_ptr_ff;
    logic             nxt_wr_ptr;
    logic             rd_ptr_ff;
    logic             nxt_rd_ptr;
    logic [1:0]       count_ff;
    logic [1:0]       nxt_count;
    logic             do_push;
    logic             do_pop;

    assign o_in_ready  = (count_ff != 2'h2);
    assign o_out_valid = (count_ff != 2'h0);
    assign o_out_data  = mem_ff[rd_ptr_ff];

    // =========================================================
    // Next state
    always_comb begin
        do_push    = i_in_valid & o_in_ready;
        do_pop     = o_out_valid & i_out_ready;
        nxt_mem    = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count  = count_ff;
        if (do_push) begin
            nxt_mem[wr_ptr_ff] = i_in_data;
            nxt_wr_ptr         = ~wr_ptr_ff;
        end
        if (do_pop) begin
            nxt_rd_ptr = ~rd_ptr_ff;
        end
        if (do_push && !do_pop) begin
            nxt_count = count_ff + 2'h1;
        end else if (do_pop && !do_push) begin
            nxt_count = count_ff - 2'h1;
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            mem_ff    <= nxt_mem;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end

endmodule

/* File: rtl/cip_pkg.sv */
// Types shared by the charger serial port files
package cip_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_REG,
        S_WDATA,
        S_ACK,
        S_RDATA,
        S_MACK,
        S_IGNORE
    } cip_state_type;

endpackage

/* File: rtl/cip_register_port.sv */
// Serial target port of the charger with its two control registers
//
// Notes on behaviour
// - Start: data falls, clock high; bus busy
// - Stop: data rises, clock high; back idle
// - Bytes are eight bits, MSB first, acked
// - Port may hold clock low to stall
// - Receiver pulls data low during ack clock
// - First byte: seven-bit address plus direction
// - Undefined register address gets NACK, ignored until the next start or stop
// - Bursts run over consecutive registers
// - Fault register holds faults until read
// - Thermistor fault field always shows present state
// - Fault register skipped by bursts
// - Input limit: binary weighted, 100 mA offset
// - Source detection overwrites input limit field
// - Pin select: 00 drives, 11 floats
// - Watchdog kick bit clears itself
// - Boost enable overrides charge enable
// - Charge needs pin low and bit set
// - Floor voltage field, reset code 101
// - Bit 0 picks boost battery threshold
// - Answers at target address 6B hex
// - Reads beyond last register return FF
`timescale 1ns/1ps
`include "cip_defines.svh"

module cip_register_port (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    // Serial bus pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_scl_out,
    output logic            o_scl_oe,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    output logic            o_bus_busy,
    // Charger events and conditions
    input  wire logic       i_charge_enable_n,
    input  wire logic       i_register_reset,
    input  wire logic       i_watchdog_expired,
    input  wire logic       i_detect_done,
    input  wire logic [4:0] i_detect_limit,
    input  wire logic [4:0] i_fault_events,
    input  wire logic [2:0] i_thermistor_fault,
    // Control fields
    output logic            o_high_impedance_enable,
    output logic [1:0]      o_indicator_pin_select,
    output logic            o_indicator_pin_float,
    output logic [4:0]      o_input_current_limit,
    output logic            o_pulse_freq_mode_disable,
    output logic            o_watchdog_kick,
    output logic            o_boost_output_enable,
    output logic            o_charge_active,
    output logic [2:0]      o_system_floor_voltage,
    output logic            o_boost_battery_threshold_sel
);
    import cip_pkg::*;

    // =========================================================
    // Pin synchronisers
    logic [2:0] pin_raw;
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic       scl_s;
    logic       sda_s;
    logic       ce_n_s;
    logic       scl_prev_ff;
    logic       sda_prev_ff;

    assign pin_raw = {i_charge_enable_n, i_sda, i_scl};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
                meta_ff[g] <= 1'b1;
                sync_ff[g] <= 1'b1;
            end else begin
                meta_ff[g] <= pin_raw[g];
                sync_ff[g] <= meta_ff[g];
            end
        end
    end

    assign scl_s  = sync_ff[0];
    assign sda_s  = sync_ff[1];
    assign ce_n_s = sync_ff[2];

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_prev_ff <= scl_s;
            sda_prev_ff <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_rise   = scl_s & ~scl_prev_ff;
    assign scl_fall   = ~scl_s & scl_prev_ff;
    assign start_seen = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
    assign stop_seen  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

    // =========================================================
    // Write buffer between bus and register file
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic        buf_out_ready;
    logic [15:0] buf_out_data;
    logic [7:0]  ptr_ff;
    logic [7:0]  shift_ff;

    assign buf_out_ready = ~i_detect_done;

    cip_pair_buffer #(
        .WIDTH (16)
    ) u_wbuf (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_in_valid  (buf_in_valid),
        .o_in_ready  (buf_in_ready),
        .i_in_data   ({ptr_ff, shift_ff}),
        .o_out_valid (buf_out_valid),
        .i_out_ready (buf_out_ready),
        .o_out_data  (buf_out_data)
    );

    // =========================================================
    // Bus state machine
    cip_state_type state_ff;
    cip_state_type nxt_state;
    cip_state_type ack_next_ff;
    cip_state_type nxt_ack_next;
    logic [3:0]    cnt_ff;
    logic [3:0]    nxt_cnt;
    logic [7:0]    nxt_shift;
    logic [7:0]    tx_ff;
    logic [7:0]    nxt_tx;
    logic [7:0]    nxt_ptr;
    logic [7:0]    next_ptr;
    logic [7:0]    rd_byte;
    logic          sda_oe_ff;
    logic          nxt_sda_oe;
    logic          scl_oe_ff;
    logic          nxt_scl_oe;
    logic          wr_pend_ff;
    logic          nxt_wr_pend;
    logic          mack_ff;
    logic          nxt_mack;
    logic          busy_ff;
    logic          nxt_busy;
    logic          do_load;
    logic          fault_read;
    logic [7:0]    reg0_ff;
    logic [7:0]    reg1_ff;
    logic [4:0]    fault_latch_ff;

    // Bursts step over the fault register and stop at the top
    always_comb begin
        if (ptr_ff == `CIP_SKIP_FROM || ptr_ff == `CIP_FAULT_REG) begin
            next_ptr = `CIP_AFTER_FAULT;
        end else if (ptr_ff == `CIP_PTR_MAX) begin
            next_ptr = `CIP_PTR_MAX;
        end else begin
            next_ptr = ptr_ff + 8'h01;
        end
        if (ptr_ff == `CIP_OFS_INPUT_CTRL) begin
            rd_byte = reg0_ff;
        end else if (ptr_ff == `CIP_OFS_CHARGE_CTRL) begin
            rd_byte = reg1_ff;
        end else if (ptr_ff == `CIP_FAULT_REG) begin
            rd_byte = {fault_latch_ff, i_thermistor_fault};
        end else if (ptr_ff > `CIP_LAST_REG) begin
            rd_byte = `CIP_BEYOND_VALUE;
        end else begin
            rd_byte = `CIP_EMPTY_VALUE;
        end
    end

    always_comb begin
        nxt_state    = state_ff;
        nxt_ack_next = ack_next_ff;
        nxt_cnt      = cnt_ff;
        nxt_shift    = shift_ff;
        nxt_tx       = tx_ff;
        nxt_ptr      = ptr_ff;
        nxt_sda_oe   = sda_oe_ff;
        nxt_scl_oe   = 1'b0;
        nxt_wr_pend  = wr_pend_ff;
        nxt_mack     = mack_ff;
        nxt_busy     = busy_ff;
        buf_in_valid = 1'b0;
        do_load      = 1'b0;
        if (stop_seen) begin
            nxt_state   = S_IDLE;
            nxt_sda_oe  = 1'b0;
            nxt_wr_pend = 1'b0;
            nxt_busy    = 1'b0;
        end else if (start_seen) begin
            nxt_state   = S_ADDR;
            nxt_cnt     = 4'h0;
            nxt_sda_oe  = 1'b0;
            nxt_wr_pend = 1'b0;
            nxt_busy    = 1'b1;
        end else begin
            unique case (state_ff)
                S_IDLE, S_IGNORE: begin
                    nxt_sda_oe = 1'b0;
                end
                S_ADDR, S_REG, S_WDATA: begin
                    if (wr_pend_ff) begin
                        buf_in_valid = 1'b1;
                        if (buf_in_ready) begin
                            // Keep the clock low one more cycle so the ack settles first
                            nxt_scl_oe   = 1'b1;
                            nxt_wr_pend  = 1'b0;
                            nxt_sda_oe   = 1'b1;
                            nxt_ptr      = next_ptr;
                            nxt_ack_next = S_WDATA;
                            nxt_state    = S_ACK;
                        end else begin
                            nxt_scl_oe = 1'b1;
                        end
                    end else if (scl_rise && cnt_ff != `CIP_BYTE_BITS) begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_cnt   = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == `CIP_BYTE_BITS) begin
                        if (state_ff == S_ADDR) begin
                            if (shift_ff[7:1] == `CIP_TARGET_ADDR) begin
                                nxt_sda_oe   = 1'b1;
                                nxt_state    = S_ACK;
                                nxt_ack_next = shift_ff[0] ? S_RDATA : S_REG;
                            end else begin
                                nxt_state = S_IGNORE;
                            end
                        end else if (state_ff == S_REG) begin
                            if (shift_ff <= `CIP_LAST_REG) begin
                                nxt_ptr      = shift_ff;
                                nxt_sda_oe   = 1'b1;
                                nxt_state    = S_ACK;
                                nxt_ack_next = S_WDATA;
                            end else begin
                                nxt_state = S_IGNORE;
                            end
                        end else begin
                            nxt_wr_pend = 1'b1;
                            nxt_scl_oe  = 1'b1;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        nxt_cnt    = 4'h0;
                        nxt_shift  = 8'h00;
                        nxt_sda_oe = 1'b0;
                        nxt_state  = ack_next_ff;
                        do_load    = (ack_next_ff == S_RDATA);
                    end
                end
                S_RDATA: begin
                    if (scl_fall) begin
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == `CIP_LAST_BIT) begin
                            nxt_sda_oe = 1'b0;
                            nxt_state  = S_MACK;
                        end else begin
                            nxt_tx     = {tx_ff[6:0], 1'b0};
                            nxt_sda_oe = ~tx_ff[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        nxt_mack = ~sda_s;
                    end
                    if (scl_fall) begin
                        if (mack_ff) begin
                            nxt_state = S_RDATA;
                            nxt_cnt   = 4'h0;
                            do_load   = 1'b1;
                        end else begin
                            nxt_state = S_IGNORE;
                        end
                    end
                end
            endcase
        end
        if (do_load) begin
            nxt_tx     = rd_byte;
            nxt_sda_oe = ~rd_byte[7];
            nxt_ptr    = next_ptr;
        end
    end

    assign fault_read = do_load & (ptr_ff == `CIP_FAULT_REG);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff    <= S_IDLE;
            ack_next_ff <= S_IDLE;
            cnt_ff      <= 4'h0;
            shift_ff    <= 8'h00;
            tx_ff       <= 8'h00;
            ptr_ff      <= 8'h00;
            sda_oe_ff   <= 1'b0;
            scl_oe_ff   <= 1'b0;
            wr_pend_ff  <= 1'b0;
            mack_ff     <= 1'b0;
            busy_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            ack_next_ff <= nxt_ack_next;
            cnt_ff      <= nxt_cnt;
            shift_ff    <= nxt_shift;
            tx_ff       <= nxt_tx;
            ptr_ff      <= nxt_ptr;
            sda_oe_ff   <= nxt_sda_oe;
            scl_oe_ff   <= nxt_scl_oe;
            wr_pend_ff  <= nxt_wr_pend;
            mack_ff     <= nxt_mack;
            busy_ff     <= nxt_busy;
        end
    end

    // Open-drain pins only ever pull low
    assign o_scl_out  = 1'b0;
    assign o_sda_out  = 1'b0;
    assign o_scl_oe   = scl_oe_ff;
    assign o_sda_oe   = sda_oe_ff;
    assign o_bus_busy = busy_ff;

    // =========================================================
    // Register file
    logic [7:0] nxt_reg0;
    logic [7:0] nxt_reg1;
    logic [4:0] nxt_fault_latch;
    logic       kick_ff;
    logic       nxt_kick;
    logic       charge_ff;
    logic       nxt_charge;
    logic       float_ff;
    logic       nxt_float;

    always_comb begin
        nxt_reg0 = reg0_ff;
        nxt_reg1 = reg1_ff;
        nxt_kick = 1'b0;
        // Reading shows the latch, then reloads it with present faults
        nxt_fault_latch = fault_read ? i_fault_events
                                     : (fault_latch_ff | i_fault_events);
        if (i_register_reset) begin
            nxt_reg0 = `CIP_RST_INPUT_CTRL;
            nxt_reg1 = `CIP_RST_CHARGE_CTRL;
        end else if (i_watchdog_expired) begin
            nxt_reg0 = (reg0_ff & ~`CIP_WD_MASK_INPUT)
                     | (`CIP_RST_INPUT_CTRL & `CIP_WD_MASK_INPUT);
            nxt_reg1 = (reg1_ff & ~`CIP_WD_MASK_CHARGE)
                     | (`CIP_RST_CHARGE_CTRL & `CIP_WD_MASK_CHARGE);
        end else if (buf_out_valid && buf_out_ready) begin
            if (buf_out_data[15:8] == `CIP_OFS_INPUT_CTRL) begin
                nxt_reg0 = buf_out_data[7:0];
            end else if (buf_out_data[15:8] == `CIP_OFS_CHARGE_CTRL) begin
                nxt_reg1 = buf_out_data[7:0];
                nxt_reg1[`CIP_KICK_BIT] = 1'b0;
                nxt_kick = buf_out_data[`CIP_KICK_BIT];
            end
        end else if (i_detect_done) begin
            nxt_reg0[`CIP_ILIM_HI:0] = i_detect_limit;
        end
        nxt_charge = nxt_reg1[`CIP_CHG_BIT] & ~ce_n_s
                   & ~nxt_reg1[`CIP_BOOST_BIT];
        nxt_float  = (nxt_reg0[`CIP_PIN_SEL_HI:`CIP_PIN_SEL_LO] == `CIP_PIN_FLOAT_CODE);
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            reg0_ff        <= `CIP_RST_INPUT_CTRL;
            reg1_ff        <= `CIP_RST_CHARGE_CTRL;
            fault_latch_ff <= 5'h00;
            kick_ff        <= 1'b0;
            charge_ff      <= 1'b0;
            float_ff       <= 1'b0;
        end else begin
            reg0_ff        <= nxt_reg0;
            reg1_ff        <= nxt_reg1;
            fault_latch_ff <= nxt_fault_latch;
            kick_ff        <= nxt_kick;
            charge_ff      <= nxt_charge;
            float_ff       <= nxt_float;
        end
    end

    assign o_high_impedance_enable       = reg0_ff[`CIP_HIZ_BIT];
    assign o_indicator_pin_select        = reg0_ff[`CIP_PIN_SEL_HI:`CIP_PIN_SEL_LO];
    assign o_indicator_pin_float         = float_ff;
    assign o_input_current_limit         = reg0_ff[`CIP_ILIM_HI:0];
    assign o_pulse_freq_mode_disable     = reg1_ff[`CIP_PFM_BIT];
    assign o_watchdog_kick               = kick_ff;
    assign o_boost_output_enable         = reg1_ff[`CIP_BOOST_BIT];
    assign o_charge_active               = charge_ff;
    assign o_system_floor_voltage        = reg1_ff[`CIP_FLOOR_HI:`CIP_FLOOR_LO];
    assign o_boost_battery_threshold_sel = reg1_ff[`CIP_BATSEL_BIT];

    // =========================================================
    // Assertions
    a_stop_to_idle: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        stop_seen |=> (state_ff == S_IDLE) && !o_bus_busy && !o_sda_oe)
        else $error("stop did not return port to idle");

    a_start_busy: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (start_seen && !stop_seen) |=> (state_ff == S_ADDR) && o_bus_busy)
        else $error("start did not mark bus busy");

    a_nack_undef: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (state_ff == S_REG && scl_fall && cnt_ff == 4'h8 && shift_ff > 8'h0B
         && !start_seen && !stop_seen) |=> (state_ff == S_IGNORE) && !o_sda_oe)
        else $error("undefined register address was acknowledged");

    a_boost_override: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_boost_output_enable |-> !o_charge_active)
        else $error("charging while boost enabled");

    a_kick_selfclear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_watchdog_kick |=> !o_watchdog_kick && !reg1_ff[6])
        else $error("watchdog kick did not clear");

    a_reg_reset: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_register_reset |=> (reg0_ff == 8'h17) && (reg1_ff == 8'h1A))
        else $error("register reset did not restore defaults");

    a_read_beyond: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (do_load && ptr_ff > 8'h0B && !start_seen && !stop_seen)
        |=> (tx_ff == 8'hFF) && !o_sda_oe)
        else $error("read beyond last register not FF");

    a_stretch_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (wr_pend_ff && !buf_in_ready && !start_seen && !stop_seen) |=> o_scl_oe)
        else $error("clock not held while buffer full");

    a_ack_drive: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (state_ff == S_ACK) |-> o_sda_oe)
        else $error("data line released during acknowledge");

    a_fault_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_fault_events != 5'h00)
        |=> ((fault_latch_ff & $past(i_fault_events)) == $past(i_fault_events)))
        else $error("fault event not latched");

endmodule

/* File: tb/charger_i2c_register_port_tb.sv */
// Self-checking bench for the charger serial register port
`timescale 1ns/1ps
module charger_i2c_register_port_tb;
    logic       i_mclk = 1'b0, i_resetn = 1'b0, i_charge_enable_n;
    logic       i_register_reset, i_watchdog_expired, i_detect_done;
    logic [4:0] i_detect_limit, i_fault_events;
    logic [2:0] i_thermistor_fault;
    logic       o_scl_out, o_sda_out;
    logic       o_scl_oe, o_sda_oe, o_bus_busy, o_high_impedance_enable, o_indicator_pin_float;
    logic       o_pulse_freq_mode_disable, o_watchdog_kick, o_boost_output_enable;
    logic       o_charge_active, o_boost_battery_threshold_sel, m_scl_oe, m_sda_oe, a;
    logic [1:0] o_indicator_pin_select;
    logic [4:0] o_input_current_limit;
    logic [2:0] o_system_floor_voltage;
    logic [7:0] q;
    logic       stretched = 1'b0;
    logic       kicked = 1'b0;
    int         stretch_len = 0;
    int         fail_count = 0;
    int         samples_checked = 0;
    wire        i_scl = o_scl_oe ? o_scl_out : !m_scl_oe;
    wire        i_sda = o_sda_oe ? o_sda_out : !m_sda_oe;
    cip_register_port uut (.*);
    cip_master_model m (.i_mclk, .i_scl, .i_sda, .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
    initial forever #5 i_mclk = ~i_mclk;
    // A real stall holds the clock far longer than the short hold per byte
    always @(posedge i_mclk) begin
        stretch_len <= o_scl_oe ? stretch_len + 1 : 0;
        if (stretch_len > 8)
            stretched <= 1'b1;
        if (o_watchdog_kick)
            kicked <= 1'b1;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One transfer: pointer write, then data bytes written or read
    task automatic xf(input logic [7:0] ra, input logic [7:0] d[$], input logic rx);
        m.cond(1);
        m.byte_x(8'hD6, 1, q, a);
        chk(o_bus_busy, 1);
        m.byte_x(ra, 1, q, a);
        if (rx) begin
            m.cond(1);
            m.byte_x(8'hD7, 1, q, a);
        end
        foreach (d[i]) begin
            m.byte_x(rx ? 8'hFF : d[i], !rx || i == d.size() - 1, q, a);
            if (rx)
                chk(q, d[i]);
        end
        chk(a, !rx);
        m.cond(0);
    endtask
    initial begin
        repeat (100000) @(posedge i_mclk);
        fail_count++;
        finish_test();
    end
    initial begin
        {i_charge_enable_n, i_register_reset, i_watchdog_expired, i_detect_done} <= 4'h0;
        i_detect_limit <= 5'h0A;
        i_fault_events <= 5'h00;
        i_thermistor_fault <= 3'h5;
        repeat (20) @(posedge i_mclk);
        i_resetn <= 1'b1;
        m.wt(4);
        xf(8'h00, '{8'h17, 8'h1A}, 1);
        xf(8'h00, '{8'hE3, 8'h5F}, 0);
        chk({o_indicator_pin_float, o_input_current_limit}, 8'h23);
        chk({o_charge_active, o_system_floor_voltage, o_boost_battery_threshold_sel}, 8'h1F);
        i_charge_enable_n <= 1'b1;
        m.wt(5);
        chk(o_charge_active, 0);
        i_charge_enable_n <= 1'b0;
        xf(8'h00, '{8'hE3, 8'h1F}, 1);
        chk(kicked, 1);
        xf(8'h01, '{8'hB0}, 0);
        chk(o_charge_active, 0);
        chk({o_charge_active, o_boost_output_enable, o_high_impedance_enable,
             o_indicator_pin_select, o_pulse_freq_mode_disable}, 8'h1F);
        $display("register writes done");
        @(posedge i_mclk) i_watchdog_expired <= 1'b1;
        @(posedge i_mclk) i_watchdog_expired <= 1'b0;
        i_detect_done <= 1'b1;
        i_fault_events <= 5'h11;
        @(posedge i_mclk) i_detect_done <= 1'b0;
        i_fault_events <= 5'h00;
        xf(8'h00, '{8'h6A, 8'h90}, 1);
        xf(8'h09, '{8'h8D}, 1);
        i_thermistor_fault <= 3'h2;
        xf(8'h09, '{8'h02}, 1);
        xf(8'h08, '{8'h00, 8'h00}, 1);
        xf(8'h0B, '{8'h00, 8'hFF}, 1);
        m.cond(1);
        m.byte_x(8'hD6, 1, q, a);
        m.byte_x(8'h0C, 1, q, a);
        chk(a, 0);
        m.cond(1);
        m.byte_x(8'hD4, 1, q, a);
        chk(a, 0);
        m.cond(0);
        $display("reads and refusals done");
        @(posedge i_mclk) i_detect_done <= 1'b1;
        i_detect_limit <= 5'h15;
        fork
            xf(8'h02, '{8'h01, 8'h02, 8'h03}, 0);
            #6000 i_detect_done <= 1'b0;
        join
        chk(stretched, 1);
        chk(o_input_current_limit, 5'h15);
        @(posedge i_mclk) i_register_reset <= 1'b1;
        @(posedge i_mclk) i_register_reset <= 1'b0;
        xf(8'h00, '{8'h17, 8'h1A}, 1);
        chk(o_bus_busy, 0);
        chk(m.tmo != 0, 0);
        $display("stall and reset done");
        finish_test();
    end
endmodule

/* File: tb/cip_master_model.sv */
// Bus master model driving the open-drain clock and data lines
`timescale 1ns/1ps
module cip_master_model (
    input  wire logic i_mclk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_oe = 1'b0,
    output logic      o_sda_oe = 1'b0
);
    int tmo = 0;
    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // Start when s is 1, stop when 0
    task automatic cond(input logic s);
        o_sda_oe <= !s;
        wt(2);
        o_scl_oe <= 1'b0;
        wt(4);
        o_sda_oe <= s;
        wt(4);
        o_scl_oe <= s;
        wt(2);
    endtask
    // Data moves only while the clock is low; a stretch is waited out
    task automatic bit_x(input logic b, output logic r);
        int n = 0;
        o_sda_oe <= !b;
        wt(2);
        o_scl_oe <= 1'b0;
        do begin
            wt(1);
            n++;
        end while (!i_scl && n < 1000);
        tmo += int'(n == 1000);
        wt(1);
        r = i_sda;
        wt(2);
        o_scl_oe <= 1'b1;
        wt(2);
    endtask
    task automatic byte_x(input logic [7:0] d, input logic nack,
                          output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(nack, r);
        ack = !r;
    endtask
endmodule
